// ---- inc/char_disp_pkg.sv ----
package char_disp_pkg;

   localparam int DATA_W = 8;
   localparam int DD_AW  = 7;
   localparam int CG_AW  = 6;
   localparam int ADDR_W = 8;

   // apb byte offsets
   localparam logic [ADDR_W-1:0] INSTR_OFS  = 8'h00;
   localparam logic [ADDR_W-1:0] DATA_OFS   = 8'h04;
   localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h08;
   localparam logic [ADDR_W-1:0] SHIFT_OFS  = 8'h0C;

   localparam logic [DATA_W-1:0] SPACE_CODE = 8'h20;
   localparam logic [DATA_W-1:0] GLYPH_FILL = 8'h00;
   localparam logic [DD_AW-1:0]  DD_HOME    = 7'h00;
   localparam logic [DD_AW-1:0]  SHIFT_NONE = 7'h00;

   // instruction opcode bits, highest set bit selects the instruction
   localparam int OP_DD_SET_BIT = 7;
   localparam int OP_CG_SET_BIT = 6;
   localparam int OP_FUNC_BIT   = 5;
   localparam int OP_SHIFT_BIT  = 4;
   localparam int OP_DISP_BIT   = 3;
   localparam int OP_ENTRY_BIT  = 2;
   localparam int OP_HOME_BIT   = 1;
   localparam int OP_CLEAR_BIT  = 0;

   // instruction field positions
   localparam int ENTRY_ID_BIT = 1;
   localparam int ENTRY_S_BIT  = 0;
   localparam int DISP_D_BIT   = 2;
   localparam int DISP_C_BIT   = 1;
   localparam int DISP_B_BIT   = 0;
   localparam int FUNC_DL_BIT  = 4;
   localparam int FUNC_N_BIT   = 3;
   localparam int FUNC_BR_LSB  = 0;
   localparam int SHIFT_SC_BIT = 3;
   localparam int SHIFT_RL_BIT = 2;
   localparam int BUSY_BIT     = 7;

   // reset values
   localparam logic       RST_DISPLAY_ON = 1'b0;
   localparam logic       RST_CURSOR_ON  = 1'b0;
   localparam logic       RST_BLINK_ON   = 1'b0;
   localparam logic       RST_INCREMENT  = 1'b1;
   localparam logic       RST_SHIFT_EN   = 1'b0;
   localparam logic       RST_WIDTH_8BIT = 1'b1;
   localparam logic       RST_TWO_LINES  = 1'b1;
   localparam logic [1:0] RST_LUMINANCE  = 2'h0;

   typedef enum logic [1:0] {
      MODE_PAR_RW_EN = 2'b00,
      MODE_PAR_WR_RD = 2'b01,
      MODE_SERIAL    = 2'b10
   } host_mode_e;

   typedef enum logic {
      TGT_DISPLAY = 1'b0,
      TGT_GLYPH   = 1'b1
   } target_e;

   typedef struct packed {
      host_mode_e host_mode;
      target_e    target;
      logic [1:0] luminance_level;
      logic       line_count_select;
      logic       bus_width_select;
      logic       shift_enable;
      logic       increment_select;
      logic       blink_on;
      logic       cursor_on;
      logic       display_on;
   } disp_cfg_s;

   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0]       pwdata;
   } apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } apb_rsp_s;

endpackage : char_disp_pkg

// ---- rtl/char_ram.sv ----
`timescale 1ns/1ps
module char_ram
   import char_disp_pkg::*;
#(
   parameter int              AW   = 7,
   parameter logic [DATA_W-1:0] FILL = 8'h20
) (
   input  wire logic              clk_i,
   input  wire logic              rst_b_i,
   input  wire logic              clear_i,
   input  wire logic              we_i,
   input  wire logic [AW-1:0]     addr_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   output logic      [DATA_W-1:0] rdata_o
);

   localparam int DEPTH = 2 ** AW;

   typedef struct packed {
      logic [DEPTH-1:0] valid;
   } ram_state_s;

   ram_state_s        s_q;
   ram_state_s        s_d;
   logic [DATA_W-1:0] mem [DEPTH];

   // per-word valid flags give an instant fill without a sweep of the array
   always_comb begin
      s_d = s_q;
      if (clear_i) begin
         s_d.valid = '0;
      end
      if (we_i) begin
         s_d.valid[addr_i] = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem[addr_i] <= wdata_i;
      end
   end

   assign rdata_o = s_q.valid[addr_i] ? mem[addr_i] : FILL;

endmodule : char_ram

// ---- rtl/apb_port.sv ----
`timescale 1ns/1ps
module apb_port
   import char_disp_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   input  apb_req_s         req_i,
   input  wire logic [31:0] rd_word_i,
   input  wire logic        mapped_i,
   output apb_rsp_s         rsp_o,
   output logic             wr_stb_o,
   output logic             rd_stb_o
);

   apb_rsp_s s_q;
   apb_rsp_s s_d;
   logic     done;

   // answer always one cycle after setup: no wait states
   assign done = req_i.psel & req_i.penable & s_q.pready;

   always_comb begin
      s_d = s_q;
      if (req_i.psel && !req_i.penable) begin
         s_d.pready  = 1'b1;
         s_d.pslverr = !mapped_i;
         s_d.prdata  = req_i.pwrite ? 32'h0000_0000 : rd_word_i;
      end else if (done) begin
         s_d.pready  = 1'b0;
         s_d.pslverr = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // erroring transfers have no side effect
   assign wr_stb_o = done & req_i.pwrite & !s_q.pslverr;
   assign rd_stb_o = done & !req_i.pwrite & !s_q.pslverr;
   assign rsp_o    = s_q;

endmodule : apb_port

// ---- rtl/char_disp_core.sv ----
// Contract
// [R1] data write stores byte at counter
// [R2] write target is last address-set kind; a cursor/display shift instruction also selects display ram
// [R3] after write step counter, maybe shift
// [R4] data read returns byte at counter
// [R5] read source is last address-set kind; a cursor/display shift instruction also selects display ram
// [R6] after read step counter, maybe shift
// [R7] host sets address before reading data
// [R8] reset fills display ram with spaces
// [R9] reset counter zero, display ram target
// [R10] reset restores unshifted display mapping
// [R11] reset increments on, shifting off
// [R12] reset display, cursor, blink off
// [R13] reset eight-bit, two lines, full brightness
// [R14] host mode from jumpers, default parallel
// [R15] counter seven or six bits wide
// [R16] direction: decrement right, increment left
// [R17] busy flag always reads zero
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps
module char_disp_core
   import char_disp_pkg::*;
(
   input  wire logic              CLK_I,
   input  wire logic              RST_B_I,
   input  apb_req_s               APB_I,
   input  wire logic [1:0]        JUMPER_I,
   output apb_rsp_s               APB_O,
   output disp_cfg_s              DISP_CFG_O,
   output logic      [DD_AW-1:0]  CURSOR_ADDR_O,
   output logic      [DD_AW-1:0]  SHIFT_OFS_O
);

   typedef struct packed {
      disp_cfg_s        cfg;
      logic [DD_AW-1:0] ac;
      logic [DD_AW-1:0] shift_ofs;
      logic             strap_done;
   } core_state_s;

   core_state_s       s_q;
   core_state_s       s_d;
   logic              wr_stb;
   logic              rd_stb;
   logic              mapped;
   logic [31:0]       rd_word;
   logic [DATA_W-1:0] dd_rdata;
   logic [DATA_W-1:0] cg_rdata;
   logic [DATA_W-1:0] ram_byte;
   logic              dd_we;
   logic              cg_we;
   logic              dd_clear;
   logic [DATA_W-1:0] wbyte;
   logic              data_acc;

   // [R15] counter wraps at the width of the target
   function automatic logic [DD_AW-1:0] step_ac(input logic [DD_AW-1:0] ac,
                                                input logic             incr,
                                                input target_e          tgt);
      logic [DD_AW-1:0] nxt;
      nxt = incr ? ac + 7'h01 : ac - 7'h01;
      if (tgt == TGT_GLYPH) begin
         nxt[DD_AW-1] = 1'b0;
      end
      return nxt;
   endfunction : step_ac

   // [R16] left shift moves offset up, right shift down
   function automatic logic [DD_AW-1:0] shift_step(input logic [DD_AW-1:0] ofs,
                                                   input logic             left);
      return left ? ofs + 7'h01 : ofs - 7'h01;
   endfunction : shift_step

   // [R14] illegal jumper code falls back to factory mode
   function automatic host_mode_e decode_mode(input logic [1:0] j);
      host_mode_e m;
      unique case (j)
         2'b00:   m = MODE_PAR_RW_EN;
         2'b01:   m = MODE_PAR_WR_RD;
         2'b10:   m = MODE_SERIAL;
         default: m = MODE_PAR_RW_EN;
      endcase
      return m;
   endfunction : decode_mode

   apb_port u_apb (
      .clk_i     (CLK_I),
      .rst_b_i   (RST_B_I),
      .req_i     (APB_I),
      .rd_word_i (rd_word),
      .mapped_i  (mapped),
      .rsp_o     (APB_O),
      .wr_stb_o  (wr_stb),
      .rd_stb_o  (rd_stb)
   );

   // [R8] cleared words read back as space
   char_ram #(.AW(DD_AW), .FILL(SPACE_CODE)) u_dd_ram (
      .clk_i   (CLK_I),
      .rst_b_i (RST_B_I),
      .clear_i (dd_clear),
      .we_i    (dd_we),
      .addr_i  (s_q.ac),
      .wdata_i (wbyte),
      .rdata_o (dd_rdata)
   );

   char_ram #(.AW(CG_AW), .FILL(GLYPH_FILL)) u_cg_ram (
      .clk_i   (CLK_I),
      .rst_b_i (RST_B_I),
      .clear_i (1'b0),
      .we_i    (cg_we),
      .addr_i  (s_q.ac[CG_AW-1:0]),
      .wdata_i (wbyte),
      .rdata_o (cg_rdata)
   );

   assign wbyte = APB_I.pwdata[DATA_W-1:0];
   // [R5] read source follows last address set; a shift instruction selects display ram
   assign ram_byte = (s_q.cfg.target == TGT_GLYPH) ? cg_rdata : dd_rdata;
   assign data_acc = (wr_stb || rd_stb) && APB_I.paddr == DATA_OFS;

   always_comb begin
      rd_word = 32'h0000_0000;
      mapped  = 1'b1;
      unique case (APB_I.paddr)
         // [R17] busy flag fixed at zero
         INSTR_OFS:  rd_word[DATA_W-1:0] = {1'b0, s_q.ac};
         // [R4] byte at counter onto read data
         DATA_OFS:   rd_word[DATA_W-1:0] = ram_byte;
         STATUS_OFS: rd_word[$bits(disp_cfg_s)-1:0] = s_q.cfg;
         SHIFT_OFS:  rd_word[DD_AW-1:0] = s_q.shift_ofs;
         default:    mapped = 1'b0;
      endcase
   end

   always_comb begin
      s_d      = s_q;
      dd_we    = 1'b0;
      cg_we    = 1'b0;
      dd_clear = 1'b0;
      // strap caught once, after reset release
      if (!s_q.strap_done) begin
         s_d.strap_done    = 1'b1;
         s_d.cfg.host_mode = decode_mode(JUMPER_I);
      end
      if (wr_stb && APB_I.paddr == INSTR_OFS) begin
         if (wbyte[OP_DD_SET_BIT]) begin
            s_d.ac         = wbyte[DD_AW-1:0];
            s_d.cfg.target = TGT_DISPLAY;
         end else if (wbyte[OP_CG_SET_BIT]) begin
            s_d.ac         = {1'b0, wbyte[CG_AW-1:0]};
            s_d.cfg.target = TGT_GLYPH;
         end else if (wbyte[OP_FUNC_BIT]) begin
            s_d.cfg.bus_width_select  = wbyte[FUNC_DL_BIT];
            s_d.cfg.line_count_select = wbyte[FUNC_N_BIT];
            s_d.cfg.luminance_level   = wbyte[FUNC_BR_LSB+:2];
         end else if (wbyte[OP_SHIFT_BIT]) begin
            // cursor moves always address display ram afterwards
            s_d.cfg.target = TGT_DISPLAY;
            s_d.ac = step_ac(s_q.ac, wbyte[SHIFT_RL_BIT], TGT_DISPLAY);
            if (wbyte[SHIFT_SC_BIT]) begin
               s_d.shift_ofs = shift_step(s_q.shift_ofs, !wbyte[SHIFT_RL_BIT]);
            end
         end else if (wbyte[OP_DISP_BIT]) begin
            s_d.cfg.display_on = wbyte[DISP_D_BIT];
            s_d.cfg.cursor_on  = wbyte[DISP_C_BIT];
            s_d.cfg.blink_on   = wbyte[DISP_B_BIT];
         end else if (wbyte[OP_ENTRY_BIT]) begin
            s_d.cfg.increment_select = wbyte[ENTRY_ID_BIT];
            s_d.cfg.shift_enable     = wbyte[ENTRY_S_BIT];
         end else if (wbyte[OP_HOME_BIT] || wbyte[OP_CLEAR_BIT]) begin
            s_d.ac         = DD_HOME;
            s_d.cfg.target = TGT_DISPLAY;
            s_d.shift_ofs  = SHIFT_NONE;
            if (!wbyte[OP_HOME_BIT]) begin
               dd_clear                 = 1'b1;
               s_d.cfg.increment_select = RST_INCREMENT;
            end
         end
      end
      if (data_acc) begin
         // [R1] store byte at the counter
         if (wr_stb) begin
            // [R2] write target from last address set; a shift instruction selects display ram
            dd_we = (s_q.cfg.target == TGT_DISPLAY);
            cg_we = (s_q.cfg.target == TGT_GLYPH);
         end
         // [R3] [R6] step counter after access
         s_d.ac = step_ac(s_q.ac, s_q.cfg.increment_select, s_q.cfg.target);
         // display shift only when display ram is touched
         if (s_q.cfg.shift_enable && s_q.cfg.target == TGT_DISPLAY) begin
            s_d.shift_ofs = shift_step(s_q.shift_ofs, s_q.cfg.increment_select);
         end
      end
   end

   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         // [R9] [R10] counter home, display target, unshifted
         s_q.ac                    <= DD_HOME;
         s_q.shift_ofs             <= SHIFT_NONE;
         s_q.cfg.target            <= TGT_DISPLAY;
         s_q.cfg.host_mode         <= MODE_PAR_RW_EN;
         // [R11] entry mode defaults
         s_q.cfg.increment_select  <= RST_INCREMENT;
         s_q.cfg.shift_enable      <= RST_SHIFT_EN;
         // [R12] display control defaults
         s_q.cfg.display_on        <= RST_DISPLAY_ON;
         s_q.cfg.cursor_on         <= RST_CURSOR_ON;
         s_q.cfg.blink_on          <= RST_BLINK_ON;
         // [R13] function set defaults
         s_q.cfg.bus_width_select  <= RST_WIDTH_8BIT;
         s_q.cfg.line_count_select <= RST_TWO_LINES;
         s_q.cfg.luminance_level   <= RST_LUMINANCE;
         s_q.strap_done            <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   assign DISP_CFG_O    = s_q.cfg;
   assign CURSOR_ADDR_O = s_q.ac;
   assign SHIFT_OFS_O   = s_q.shift_ofs;

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_B_I);

   logic rd_setup;
   assign rd_setup = APB_I.psel && !APB_I.penable && !APB_I.pwrite;

   data_store_a: assert property ( // [R1]
      wr_stb && APB_I.paddr == DATA_OFS && s_q.cfg.target == TGT_DISPLAY
      |-> dd_we && !cg_we
      ##1 u_dd_ram.mem[$past(s_q.ac)] == $past(APB_I.pwdata[7:0]))
      else $error("display write not stored");

   write_target_a: assert property ( // [R2]
      wr_stb && APB_I.paddr == DATA_OFS && s_q.cfg.target == TGT_GLYPH
      |-> cg_we && !dd_we)
      else $error("glyph write went elsewhere");

   write_step_a: assert property ( // [R3]
      wr_stb && APB_I.paddr == DATA_OFS
      |=> s_q.ac == step_ac($past(s_q.ac), $past(s_q.cfg.increment_select),
                            $past(s_q.cfg.target)))
      else $error("counter not stepped after write");

   read_data_a: assert property ( // [R4]
      rd_setup && APB_I.paddr == DATA_OFS
      |=> APB_O.pready && APB_O.prdata[7:0] == $past(ram_byte))
      else $error("read byte wrong");

   read_shift_a: assert property ( // [R6]
      rd_stb && APB_I.paddr == DATA_OFS && s_q.cfg.shift_enable
      && s_q.cfg.target == TGT_DISPLAY
      |=> s_q.shift_ofs != $past(s_q.shift_ofs))
      else $error("no shift after read");

   space_fill_a: assert property ( // [R8]
      !s_q.strap_done |-> dd_rdata == SPACE_CODE && s_q.ac == DD_HOME)
      else $error("display ram not spaces after reset");

   reset_cfg_a: assert property ( // [R12]
      !s_q.strap_done |-> !s_q.cfg.display_on && !s_q.cfg.cursor_on
      && !s_q.cfg.blink_on && s_q.cfg.increment_select && !s_q.cfg.shift_enable
      && s_q.cfg.bus_width_select && s_q.cfg.line_count_select
      && s_q.cfg.luminance_level == 2'h0 && s_q.shift_ofs == 7'h00)
      else $error("reset defaults wrong");

   glyph_width_a: assert property ( // [R15]
      s_q.cfg.target == TGT_GLYPH |-> !s_q.ac[6])
      else $error("glyph address above six bits");

   dec_dir_a: assert property ( // [R16]
      data_acc && !s_q.cfg.increment_select && s_q.cfg.target == TGT_DISPLAY
      |=> s_q.ac == $past(s_q.ac) - 7'h01)
      else $error("counter did not decrement");

   busy_zero_a: assert property ( // [R17]
      rd_setup && APB_I.paddr == INSTR_OFS |=> APB_O.prdata[7] == 1'b0)
      else $error("busy flag set");

   read_source_a: assert property ( // [R5]
      rd_setup && APB_I.paddr == DATA_OFS && s_q.cfg.target == TGT_GLYPH
      |=> APB_O.prdata[7:0] == $past(cg_rdata))
      else $error("glyph read took wrong ram");

   // sampled reset in the antecedent: the release edge itself is skipped
   strap_mode_a: assert property ( // [R14]
      RST_B_I && !s_q.strap_done
      |=> s_q.cfg.host_mode == (($past(JUMPER_I) == 2'b11) ? MODE_PAR_RW_EN
                                : host_mode_e'($past(JUMPER_I))))
      else $error("host mode not taken from jumpers");

   wr_data_c: cover property (wr_stb && APB_I.paddr == DATA_OFS);
   rd_data_c: cover property (rd_stb && APB_I.paddr == DATA_OFS);
   clear_c:   cover property (dd_clear);
   glyph_c:   cover property (cg_we ##1 data_acc);

endmodule : char_disp_core

// ---- sim/host_model.sv ----
`timescale 1ns/1ps
module host_model
   import char_disp_pkg::*;
(
   input  wire logic clk_i,
   input  apb_rsp_s  rsp_i,
   output apb_req_s  req_o
);

   initial req_o = '0;

   // one apb transfer, then gap+1 idle cycles so the host can also be slow
   task automatic xfer(input logic wr, input logic [ADDR_W-1:0] addr,
                       input logic [7:0] data, input int gap);
      req_o.psel    <= 1'b1;
      req_o.penable <= 1'b0;
      req_o.pwrite  <= wr;
      req_o.paddr   <= addr;
      req_o.pwdata  <= {24'h000000, data};
      @(posedge clk_i);
      req_o.penable <= 1'b1;
      // request stands until pready is seen at an edge
      do @(posedge clk_i);
      while (rsp_i.pready !== 1'b1);
      req_o.psel    <= 1'b0;
      req_o.penable <= 1'b0;
      repeat (gap + 1) @(posedge clk_i);
   endtask : xfer

endmodule : host_model

// ---- sim/char_display_data_access_reset_bench.sv ----
`timescale 1ns/1ps
module char_display_data_access_reset_bench
   import char_disp_pkg::*;
;
   typedef struct packed {
      logic        chk_data;
      logic        err;
      logic [31:0] data;
   } note_s;

   logic             clk    = 1'b0;
   logic             rst_b  = 1'b0;
   logic [1:0]       jumper = 2'h0;
   apb_req_s         apb_req;
   apb_rsp_s         apb_rsp;
   disp_cfg_s        cfg;
   logic [DD_AW-1:0] cursor;
   logic [DD_AW-1:0] shift;
   note_s            notes[$];
   note_s            cur;
   int               fail_count = 0;
   int               num_checks = 0;
   int               seed       = 59321;
   logic [7:0]       bytes[4];

   always #2.5 clk = ~clk;

   char_disp_core uut (.CLK_I(clk), .RST_B_I(rst_b), .APB_I(apb_req), .JUMPER_I(jumper),
      .APB_O(apb_rsp), .DISP_CFG_O(cfg), .CURSOR_ADDR_O(cursor), .SHIFT_OFS_O(shift));
   host_model host (.clk_i(clk), .rsp_i(apb_rsp), .req_o(apb_req));

   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic print_verdict();
      $display("checks=%0d mismatches=%0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : print_verdict

   task automatic xact(input logic w, input logic [7:0] a, input logic [7:0] d, input note_s n);
      notes.push_back(n);
      host.xfer(w, a, d, int'($unsigned($random(seed)) % 3));
   endtask : xact

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      xact(1'b1, a, d, '{1'b0, 1'b0, 32'h0});
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
      xact(1'b0, a, 8'h00, '{1'b1, 1'b0, exp});
   endtask : rd

   task automatic do_reset(input logic [1:0] j);
      jumper <= j;
      rst_b  <= 1'b0;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
   endtask : do_reset

   function automatic disp_cfg_s reset_cfg(input logic [1:0] j);
      disp_cfg_s c;
      c = '0;
      c.host_mode = (j == 2'h3) ? MODE_PAR_RW_EN : host_mode_e'(j);
      c.target = TGT_DISPLAY;
      c.line_count_select = 1'b1;
      c.bus_width_select = 1'b1;
      c.increment_select = 1'b1;
      return c;
   endfunction : reset_cfg

   // results are compared in the order the driver noted them
   always @(posedge clk) begin
      if (rst_b && apb_req.psel && apb_req.penable && apb_rsp.pready === 1'b1) begin
         cur = notes.pop_front();
         check({apb_rsp.pslverr, cur.chk_data ? apb_rsp.prdata : 32'h0}, {cur.err, cur.data});
      end
   end

   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      print_verdict();
   end

   initial begin
      do_reset(2'h0);
      for (int j = 0; j < 4; j++) begin
         wr(INSTR_OFS, 8'h0F);
         wr(INSTR_OFS, 8'h23);
         wr(INSTR_OFS, 8'h07);
         wr(INSTR_OFS, 8'hC5);
         wr(DATA_OFS, 8'hA5);
         check(33'(cfg[8:0]), 33'h19F);
         check(33'(cursor), 33'h46);
         check(33'(shift), 33'h1);
         do_reset(j[1:0]);
         check(33'(cfg), 33'(reset_cfg(j[1:0])));
         check(33'(cursor), 33'h0);
         check(33'(shift), 33'h0);
         rd(INSTR_OFS, 32'h0);
         wr(INSTR_OFS, 8'hC5);
         rd(DATA_OFS, 32'h20);
      end
      wr(INSTR_OFS, 8'h90);
      for (int i = 0; i < 4; i++) begin
         bytes[i] = 8'($random(seed));
         wr(DATA_OFS, bytes[i]);
      end
      rd(INSTR_OFS, 32'h14);
      wr(INSTR_OFS, 8'h90);
      for (int i = 0; i < 4; i++) rd(DATA_OFS, {24'h0, bytes[i]});
      rd(INSTR_OFS, 32'h14);
      wr(INSTR_OFS, 8'h04);
      wr(INSTR_OFS, 8'h85);
      wr(DATA_OFS, 8'h3C);
      wr(DATA_OFS, 8'hC3);
      rd(INSTR_OFS, 32'h03);
      wr(INSTR_OFS, 8'h85);
      rd(DATA_OFS, 32'h3C);
      rd(DATA_OFS, 32'hC3);
      check(33'(shift), 33'h0);
      // glyph ram kept apart from display ram
      wr(INSTR_OFS, 8'h06);
      wr(INSTR_OFS, 8'h7E);
      check(33'(cfg.target), 33'(TGT_GLYPH));
      wr(DATA_OFS, 8'h5A);
      wr(DATA_OFS, 8'hA5);
      rd(INSTR_OFS, 32'h00);
      wr(INSTR_OFS, 8'hBE);
      rd(DATA_OFS, 32'h20);
      wr(INSTR_OFS, 8'h7E);
      rd(DATA_OFS, 32'h5A);
      rd(DATA_OFS, 32'hA5);
      wr(INSTR_OFS, 8'h50);
      rd(DATA_OFS, 32'h00);
      wr(INSTR_OFS, 8'h07);
      wr(DATA_OFS, 8'h11);
      check(33'(shift), 33'h0);
      wr(INSTR_OFS, 8'h80);
      wr(DATA_OFS, 8'h22);
      check(33'(shift), 33'h1);
      rd(DATA_OFS, 32'h20);
      rd(SHIFT_OFS, 32'h2);
      wr(INSTR_OFS, 8'h05);
      wr(DATA_OFS, 8'h33);
      check(33'(shift), 33'h1);
      // unmapped offset is refused, no side effect
      xact(1'b0, 8'h10, 8'h00, '{1'b0, 1'b1, 32'h0});
      xact(1'b1, 8'h10, 8'hFF, '{1'b0, 1'b1, 32'h0});
      rd(INSTR_OFS, 32'h01);
      wr(INSTR_OFS, 8'h1C);
      check(33'(cursor), 33'h02);
      check(33'(shift), 33'h00);
      wr(INSTR_OFS, 8'h02);
      check(33'(cursor), 33'h00);
      wr(DATA_OFS, 8'h44);
      check(33'(shift), 33'h7F);
      wr(INSTR_OFS, 8'h01);
      check(33'({cursor, shift, cfg.increment_select}), 33'h0001);
      rd(DATA_OFS, 32'h20);
      print_verdict();
   end

endmodule : char_display_data_access_reset_bench
